// >>> core/spc_pkg.sv
// Package for the sensor pulse clamp edges block: map, fields, types
package spc_pkg;

    // ---------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [5:0] IDX_LINE_CLAMP_ENABLES = 6'h06;
    localparam logic [5:0] IDX_PULSE1_ON_EDGE = 6'h07;
    localparam logic [5:0] IDX_PULSE1_OFF_EDGE = 6'h08;
    localparam logic [5:0] IDX_PULSE1_CONTROL = 6'h09;
    localparam logic [5:0] IDX_PULSE1_STATUS = 6'h0a;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_LINE_CLAMP_ENABLES = 8'h00;
    localparam logic [6:0] RST_PULSE1_ON_EDGE = 7'h00;
    localparam logic [6:0] RST_PULSE1_OFF_EDGE = 7'h15;
    localparam logic [2:0] RST_PULSE1_CONTROL = 3'h0;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CLAMP_BIT_PULSE1 = 0;
    localparam int CLAMP_BIT_PULSE8 = 7;
    localparam int EDGE_MSB = 6;
    localparam int CTRL_BIT_ACTIVE = 0;
    localparam int CTRL_BIT_POLARITY = 1;
    localparam int CTRL_BIT_HALF_RATE = 2;

    // Sub-pixel edges in one pixel period
    localparam int EDGES_PER_PIXEL = 24;

    // Software-visible settings carried as one group
    typedef struct packed {
        logic [7:0] clamp_en;
        logic [6:0] on_edge;
        logic [6:0] off_edge;
        logic [2:0] control;
    } spc_regs_t;

    // Clamp pulse sequencing for one line
    typedef enum logic [1:0] {
        CLAMP_IDLE = 2'b00,
        CLAMP_ARMED = 2'b01,
        CLAMP_HIGH = 2'b10
    } spc_clamp_state_t;

endpackage

// >>> core/spc_pulse_clamp.sv
// Pulse output one generator with line clamp enables and Avalon-MM slave
//
// What this block does
// RL1 - A set clamp bit makes its output give one clamp pulse per line.
// RL2 - A clear clamp bit leaves the ordinary per-pixel pulse train as is.
// RL3 - Clamp bits for outputs one to six sit at bits 0 to 5 in order.
// RL4 - A 7-bit turn-on field picks the sub-pixel edge where output one rises.
// RL5 - A 7-bit turn-off field, reset 0x15, picks the edge where it falls.
// RL6 - Turn-on and turn-off accept any edge inside one pixel period.
// RL7 - At half pixel rate the edge count spans two pixel periods.
// RL8 - Bit 7 of the clamp register enables clamp mode for output eight.
// RL9 - A polarity of 1 makes the output idle high, 0 makes it idle low.
// RL10 - The clamp pulse starts after the line start, on the set edges.
`timescale 1ns/1ns
`default_nettype none

module spc_pulse_clamp
    import spc_pkg::*;
#(
    parameter int EDGES = EDGES_PER_PIXEL
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Avalon-MM slave
    input wire logic [7:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // Sensor timing
    input wire logic LINE_START_PULSE,
    output logic PULSE_OUT_ONE,
    output logic [7:0] LINE_CLAMP_EN
);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------

    // Word index of a byte address; low two bits are the byte lane
    function automatic logic [5:0] word_index(input logic [7:0] addr);
        word_index = addr[7:2];
    endfunction

    // Wrap point of the edge counter: one or two pixel periods
    function automatic logic [7:0] edge_span(input logic half_rate);
        logic [7:0] one_span;
        one_span = 8'(EDGES);
        if (half_rate) begin
            edge_span = 8'(2 * EDGES);
        end else begin
            edge_span = one_span;
        end
    endfunction

    // True when the edge counter stands on a seven-bit edge setting
    function automatic logic edge_hit(input logic [7:0] count,
        input logic [6:0] point);
        edge_hit = count == {1'b0, point};
    endfunction

    // ---------------------------------------------------------------
    // Register file and bus slave
    // ---------------------------------------------------------------
    // Word map (byte address is four times the index):
    // 0x06 clamp enables, bit n belongs to output n+1
    // 0x07 turn-on edge and 0x08 turn-off edge, seven bits each
    // 0x09 control: active, polarity, half rate
    // 0x0a status, read only: counter, raw level, clamp state
    // Reserved bits read as zero and writes to them are dropped
    spc_regs_t regs_reg;
    spc_regs_t regs_next;
    logic wait_reg;
    logic wait_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic pulse_reg;
    logic pulse_next;
    logic [7:0] edge_reg;
    logic [7:0] edge_next;
    spc_clamp_state_t clamp_reg;
    spc_clamp_state_t clamp_next;
    logic level_reg;
    logic level_next;

    logic req;
    logic [5:0] idx;
    assign req = READ | WRITE;
    assign idx = word_index(ADDRESS);

    // One wait state per access; write lands when waitrequest is low
    always_comb begin
        regs_next = regs_reg;
        wait_next = wait_reg;
        rdata_next = rdata_reg;
        // Answer lasts one cycle even if a master drops its request early
        if (!wait_reg) begin
            wait_next = 1'b1;
        end else if (req) begin
            wait_next = 1'b0;
        end
        // Only reads load the data word, so it holds across writes
        if (READ && wait_reg) begin
            rdata_next = 32'h0000_0000;
            case (idx)
                // RL3 clamp bits in order
                IDX_LINE_CLAMP_ENABLES: rdata_next[7:0] = regs_reg.clamp_en;
                IDX_PULSE1_ON_EDGE: rdata_next[6:0] = regs_reg.on_edge;
                IDX_PULSE1_OFF_EDGE: rdata_next[6:0] = regs_reg.off_edge;
                IDX_PULSE1_CONTROL: rdata_next[2:0] = regs_reg.control;
                IDX_PULSE1_STATUS: begin
                    rdata_next[15:8] = edge_reg;
                    rdata_next[1:0] = clamp_reg;
                    rdata_next[2] = level_reg;
                end
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        if (WRITE && !wait_reg) begin
            case (idx)
                // RL3 outputs one to six, RL8 output eight
                IDX_LINE_CLAMP_ENABLES: regs_next.clamp_en = WRITEDATA[7:0];
                // RL4 turn-on edge
                IDX_PULSE1_ON_EDGE:
                    regs_next.on_edge = WRITEDATA[EDGE_MSB:0];
                // RL5 turn-off edge
                IDX_PULSE1_OFF_EDGE:
                    regs_next.off_edge = WRITEDATA[EDGE_MSB:0];
                IDX_PULSE1_CONTROL: regs_next.control = WRITEDATA[2:0];
                default: regs_next = regs_reg;
            endcase
        end
    end

    // Register update for the bus side
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            regs_reg.clamp_en <= RST_LINE_CLAMP_ENABLES;
            // RL5 off edge resets to 0x15
            regs_reg.on_edge <= RST_PULSE1_ON_EDGE;
            regs_reg.off_edge <= RST_PULSE1_OFF_EDGE;
            regs_reg.control <= RST_PULSE1_CONTROL;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            regs_reg <= regs_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    // ---------------------------------------------------------------
    // Line start qualification
    // ---------------------------------------------------------------
    logic line_seen_reg;
    logic line_seen_next;
    logic line_begin;
    assign line_begin = LINE_START_PULSE & ~line_seen_reg;

    // Only the first cycle of a line start counts, so a start held high
    // by the sensor side neither re-arms the clamp nor stalls the counter
    always_comb begin
        line_seen_next = LINE_START_PULSE;
    end

    // Line start history; resets to the idle level so no false start
    // follows reset
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            line_seen_reg <= 1'b0;
        end else begin
            line_seen_reg <= line_seen_next;
        end
    end

    // ---------------------------------------------------------------
    // Sub-pixel edge counter
    // ---------------------------------------------------------------
    logic half_rate;
    logic [7:0] span;
    assign half_rate = regs_reg.control[CTRL_BIT_HALF_RATE];
    assign span = edge_span(half_rate);

    // RL6 RL7 count every edge of one or two pixels
    // Line start realigns so the clamp pulse sits on a fixed edge; the
    // price is a short pixel at each line start if the counter was mid-way
    always_comb begin
        if (line_begin || edge_reg >= span - 8'h01) begin
            edge_next = 8'h00;
        end else begin
            edge_next = edge_reg + 8'h01;
        end
    end

    // Edge counter register
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            edge_reg <= 8'h00;
        end else begin
            edge_reg <= edge_next;
        end
    end

    // ---------------------------------------------------------------
    // Pulse and clamp generation for output one
    // ---------------------------------------------------------------
    logic hit_on;
    logic hit_off;
    logic clamp_mode;
    logic active;
    assign hit_on = edge_hit(edge_reg, regs_reg.on_edge);
    assign hit_off = edge_hit(edge_reg, regs_reg.off_edge);
    assign clamp_mode = regs_reg.clamp_en[CLAMP_BIT_PULSE1];
    assign active = regs_reg.control[CTRL_BIT_ACTIVE];

    // Edges past the span never match; software must keep them in range.
    // A match in one cycle moves the pin at the next edge, since the
    // output flop is loaded from the next level rather than the current.
    always_comb begin
        clamp_next = clamp_reg;
        level_next = level_reg;
        if (!active) begin
            clamp_next = CLAMP_IDLE;
            level_next = 1'b0;
        end else if (clamp_mode) begin
            // RL1 one pulse per line
            case (clamp_reg)
                CLAMP_IDLE: begin
                    level_next = 1'b0;
                    // RL10 armed by line start
                    if (line_begin) begin
                        clamp_next = CLAMP_ARMED;
                    end
                end
                CLAMP_ARMED: begin
                    if (hit_on) begin
                        clamp_next = CLAMP_HIGH;
                        level_next = 1'b1;
                    end
                end
                CLAMP_HIGH: begin
                    // RL10 ends on the off edge
                    if (hit_off) begin
                        clamp_next = CLAMP_IDLE;
                        level_next = 1'b0;
                    end
                end
                default: begin
                    clamp_next = CLAMP_IDLE;
                    level_next = 1'b0;
                end
            endcase
        end else begin
            // RL2 ordinary per-pixel train
            clamp_next = CLAMP_IDLE;
            // Equal on and off edges cancel, giving no pulse at all
            if (hit_on && !hit_off) begin
                level_next = 1'b1;
            end else if (hit_off) begin
                level_next = 1'b0;
            end
        end
    end

    // RL9 polarity sets the idle level
    always_comb begin
        pulse_next = level_next ^ regs_reg.control[CTRL_BIT_POLARITY];
    end

    // Pulse state registers
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            clamp_reg <= CLAMP_IDLE;
            level_reg <= 1'b0;
        end else begin
            clamp_reg <= clamp_next;
            level_reg <= level_next;
        end
    end

    // Output flop; resets low to match the reset polarity setting of 0
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= pulse_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign READDATA = rdata_reg;
    assign WAITREQUEST = wait_reg;
    assign PULSE_OUT_ONE = pulse_reg;
    // RL8 all eight clamp bits go out to the other generators
    assign LINE_CLAMP_EN = regs_reg.clamp_en;

endmodule

`default_nettype wire

// >>> sim/spc_pulse_clamp_assertions.sv
// Port checker for the pulse clamp block
`timescale 1ns/1ns
`default_nettype none
module spc_pulse_clamp_assertions
    import spc_pkg::*;
#(
    parameter int EDGES = 24
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Register bus
    input wire logic [7:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [31:0] READDATA,
    input wire logic WAITREQUEST,
    // Sensor timing
    input wire logic LINE_START_PULSE,
    input wire logic PULSE_OUT_ONE,
    input wire logic [7:0] LINE_CLAMP_EN
);
    logic [3:0] chg_reg;
    logic pin_reg;
    logic wr_clamp;
    logic [7:0] wd_lo;
    logic [5:0] idx;
    assign idx = ADDRESS[7:2];
    assign wd_lo = WRITEDATA[7:0];
    assign wr_clamp = WRITE && !WAITREQUEST && idx == IDX_LINE_CLAMP_ENABLES;
    // Pin changes per line; a write restarts the count as modes may flip
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            chg_reg <= 4'h0;
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= PULSE_OUT_ONE;
            if (LINE_START_PULSE || WRITE) begin
                chg_reg <= 4'h0;
            end else if (pin_reg != PULSE_OUT_ONE && chg_reg != 4'hf) begin
                chg_reg <= chg_reg + 4'h1;
            end
        end
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    wait_one_a: assert property ((READ || WRITE) && WAITREQUEST
        |=> !WAITREQUEST) else $error("bus answer missing");
    wait_short_a: assert property (!WAITREQUEST |=> WAITREQUEST)
        else $error("wait low too long");
    wait_idle_a: assert property (!(READ || WRITE) && WAITREQUEST
        |=> WAITREQUEST) else $error("answer without request");
    clamp_map_a: assert property (wr_clamp
        |=> LINE_CLAMP_EN == $past(wd_lo)) else $error("clamp bits wrong");
    clamp_hold_a: assert property (!wr_clamp
        |=> $stable(LINE_CLAMP_EN)) else $error("clamp bits moved");
    read_hold_a: assert property (!(READ && WAITREQUEST)
        |=> $stable(READDATA)) else $error("read data moved");
    edge_read_a: assert property (READ && !WAITREQUEST &&
        (idx == IDX_PULSE1_ON_EDGE || idx == IDX_PULSE1_OFF_EDGE)
        |-> READDATA[31:7] == 25'h0) else $error("edge upper bits set");
    clamp_read_a: assert property (READ && !WAITREQUEST &&
        idx == IDX_LINE_CLAMP_ENABLES |-> READDATA == {24'h0, LINE_CLAMP_EN})
        else $error("clamp readback wrong");
    clamp_once_a: assert property (LINE_CLAMP_EN[0] |-> chg_reg <= 4'h2)
        else $error("extra clamp pulse");
    cover property (LINE_CLAMP_EN[0] && $rose(PULSE_OUT_ONE));
    cover property (READ && !WAITREQUEST);
    cover property (wr_clamp);
endmodule
bind spc_pulse_clamp spc_pulse_clamp_assertions #(.EDGES(EDGES)) u_chk (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .LINE_START_PULSE(LINE_START_PULSE),
    .PULSE_OUT_ONE(PULSE_OUT_ONE), .LINE_CLAMP_EN(LINE_CLAMP_EN));
`default_nettype wire

// >>> sim/spc_sensor_model.sv
// Sensor-side model: line start source and pin sampler
`timescale 1ns/1ns
`default_nettype none
module spc_sensor_model (
    // Clock, reset and bench controls
    input wire logic clk,
    input wire logic rst_n,
    input wire logic send,
    input wire logic clr,
    input wire logic pin,
    // Toward the block and observations
    output logic line_start,
    output logic [7:0] high_cnt,
    output logic [7:0] rise_cnt
);
    logic pin_reg;
    // Line start lasts one cycle only, as the block expects
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_start <= 1'b0;
            pin_reg <= 1'b0;
            high_cnt <= 8'h00;
            rise_cnt <= 8'h00;
        end else begin
            line_start <= send & ~line_start;
            pin_reg <= pin;
            high_cnt <= clr ? 8'h00 : high_cnt + {7'h0, pin};
            rise_cnt <= clr ? 8'h00 : rise_cnt + {7'h0, pin & ~pin_reg};
        end
    end
endmodule
`default_nettype wire

// >>> sim/spc_pulse_clamp_tb.sv
// Self-checking bench for the pulse clamp block
`timescale 1ns/1ns
`default_nettype none
module spc_pulse_clamp_tb;
    logic ref_clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, q;
    logic waitrequest, line_start, pin, send = 1'b0, clr = 1'b0;
    logic [7:0] clamp_en, high_cnt, rise_cnt;
    int failures = 0, checks_done = 0;
    spc_pulse_clamp #(.EDGES(24)) u_spc_pulse_clamp (.REF_CLK(ref_clk),
        .RST_N(rst_n), .ADDRESS(address), .READ(read), .WRITE(write),
        .WRITEDATA(writedata), .READDATA(readdata), .WAITREQUEST(waitrequest),
        .LINE_START_PULSE(line_start), .PULSE_OUT_ONE(pin),
        .LINE_CLAMP_EN(clamp_en));
    spc_sensor_model u_spc_sensor_model (.clk(ref_clk), .rst_n(rst_n),
        .send(send), .clr(clr), .pin(pin), .line_start(line_start),
        .high_cnt(high_cnt), .rise_cnt(rise_cnt));
    initial forever #5 ref_clk = ~ref_clk;
    task wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One bus access; held until waitrequest is seen low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= ~w;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 40) begin
            failures++;
            wrap_up();
        end
    endtask
    // Settle one long period, then count pin over w samples
    task measure(input logic fire, input int w);
        repeat (52) @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        send <= fire;
        @(posedge ref_clk);
        send <= 1'b0;
        repeat (w - 1) @(posedge ref_clk);
        #1;
    endtask
    task t_regs;
        chk(pin, 32'h0);
        bus(0, 8'h18, 0);
        chk(q, 32'h0);
        bus(0, 8'h20, 0);
        chk(q, 32'h15);
        bus(0, 8'h3c, 0);
        chk(q, 32'h0);
        bus(1, 8'h18, 32'ha5);
        @(posedge ref_clk);
        chk(clamp_en, 8'ha5);
        bus(1, 8'h1c, 32'hff);
        bus(0, 8'h1c, 0);
        chk(q, 32'h7f);
    endtask
    task t_normal;
        bus(1, 8'h18, 32'hfe);
        bus(1, 8'h1c, 32'h3);
        bus(1, 8'h20, 32'h9);
        bus(1, 8'h24, 32'h1);
        measure(0, 48);
        chk(high_cnt, 8'd12);
    endtask
    task t_clamp;
        bus(1, 8'h18, 32'h1);
        measure(1, 60);
        chk({rise_cnt, high_cnt}, {8'd1, 8'd6});
        bus(0, 8'h28, 0);
        chk(q[2:0], 3'h0);
        measure(0, 60);
        chk({rise_cnt, high_cnt}, 16'h0);
        bus(1, 8'h24, 32'h3);
        measure(1, 60);
        chk({rise_cnt, high_cnt}, {8'd1, 8'd54});
    endtask
    task t_half;
        bus(1, 8'h18, 32'h0);
        bus(1, 8'h20, 32'd30);
        bus(1, 8'h24, 32'h5);
        measure(0, 96);
        chk(high_cnt, 8'd54);
    endtask
    // Last edge of the pixel on, first edge off: one-cycle pulse per pixel
    task t_edges;
        bus(1, 8'h24, 32'h1);
        bus(1, 8'h1c, 32'd23);
        bus(1, 8'h20, 32'h0);
        measure(0, 48);
        chk({rise_cnt, high_cnt}, {8'd2, 8'd2});
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_normal();
        t_clamp();
        t_half();
        t_edges();
        wrap_up();
    end
endmodule
`default_nettype wire
